// File: design/asp_pkg.sv
// Purpose: constants and types for the ascii serial command parser
// Assumes: characters arrive already framed by a uart on the same clock
// Notes: records are twelve characters; station numbers held as two bcd digits
package asp_pkg;
    localparam int ASP_REC_LEN = 12;
    localparam logic [3:0] ASP_LAST_IDX = 4'hB;
    localparam logic [3:0] ASP_REPLY_END = 4'hC;
    localparam logic [7:0] ASP_STX = 8'h02;
    localparam logic [7:0] ASP_ETX = 8'h03;
    localparam logic [7:0] ASP_ZERO = 8'h30;
    localparam logic [7:0] ASP_NINE = 8'h39;
    localparam logic [7:0] ASP_SEND_FMT_MAX = 8'h37;
    localparam logic [7:0] ASP_FMT_MAX = 8'h3B;
    localparam logic [7:0] ASP_KIND_CTRL = 8'h31;
    localparam logic [7:0] ASP_KIND_INQ = 8'h32;
    localparam logic [7:0] ASP_KIND_SEND = 8'h33;
    localparam logic [7:0] ASP_BCAST = 8'h00;
    // error character
    localparam logic [7:0] ASP_ERR_OK = 8'h40;
    localparam int ASP_ERR_RANGE_BIT = 5;
    localparam int ASP_ERR_CODE_BIT = 4;
    localparam int ASP_ERR_FMT_BIT = 3;
    localparam int ASP_ERR_DATA_BIT = 2;
    localparam int ASP_ERR_PAR_BIT = 1;
    // control command codes as two bcd digits
    localparam logic [7:0] ASP_CMD_FSTOP = 8'h01;
    localparam logic [7:0] ASP_CMD_RSTOP = 8'h02;
    localparam logic [7:0] ASP_CMD_RUN = 8'h03;
    localparam logic [7:0] ASP_CMD_MASTER = 8'h04;
    localparam logic [7:0] ASP_CMD_FOLLOW = 8'h05;
    localparam logic [7:0] ASP_CMD_SP13 = 8'h10;
    localparam logic [7:0] ASP_CMD_SP24 = 8'h11;
    // register map
    localparam logic [7:0] ASP_REG_STATION = 8'h00;
    localparam logic [7:0] ASP_REG_STATUS = 8'h04;
    localparam logic [7:0] ASP_STATION_RST = 8'h01;

    typedef enum logic [4:0] {
        ASP_IDLE = 5'b00001,
        ASP_RECV = 5'b00010,
        ASP_EVAL = 5'b00100,
        ASP_FETCH = 5'b01000,
        ASP_SEND = 5'b10000
    } asp_state_t;

    typedef logic [ASP_REC_LEN-1:0][7:0] asp_rec_t;

    typedef struct packed {
        logic [7:0] num;
        logic [15:0] data;
        logic [7:0] fmt;
    } asp_par_t;

    typedef struct packed {
        asp_state_t st;
        logic [3:0] cnt;
        asp_rec_t rec;
        logic [7:0] kind;
        logic [7:0] err;
        logic par_err;
        logic short_rec;
        logic bcast;
        logic [7:0] tx_char;
        logic tx_valid;
        logic run;
        logic master;
        logic spsel;
        logic fstop;
        logic rstop;
        logic par_wr;
        asp_par_t par;
        logic [7:0] par_num;
        logic [31:0] rdata;
        logic [7:0] station;
    } asp_regs_t;
endpackage

// File: design/asp_parser.sv
// Purpose: frames host records, checks station and fields, acts, builds replies
// Assumes: rx strobes and tx handshake come from a uart on sys_clk_i
// Notes: receive is ignored while a record is evaluated or answered
module asp_parser #(
    parameter logic [7:0] STATION_RESET = asp_pkg::ASP_STATION_RST
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    input wire logic [7:0] rx_char_i,
    input wire logic rx_valid_i,
    input wire logic rx_parity_err_i,
    output logic [7:0] tx_char_o,
    output logic tx_valid_o,
    input wire logic tx_ready_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    output logic [7:0] param_num_o,
    input wire logic [15:0] param_value_i,
    input wire logic [7:0] param_format_i,
    input wire logic param_bad_i,
    input wire logic param_range_err_i,
    output logic param_wr_o,
    output asp_pkg::asp_par_t param_wr_data_o,
    output logic run_o,
    output logic master_mode_o,
    output logic setpoint_sel_o,
    output logic fast_stop_o,
    output logic ramp_stop_o
);
    generate
        if (STATION_RESET[7:4] > 4'h9 || STATION_RESET[3:0] > 4'h9) begin : g_bad_station
            $error("station reset value must be two bcd digits");
        end
    endgenerate

    asp_pkg::asp_regs_t cur_reg, cur_next;
    logic [7:0] ev_err;
    logic [7:0] ev_station;
    logic [7:0] ev_cmd;
    logic ev_addr_ok;
    logic ev_cmd_ok;

    function automatic logic asp_is_digit(input logic [7:0] c);
        return (c >= asp_pkg::ASP_ZERO) && (c <= asp_pkg::ASP_NINE);
    endfunction

    function automatic logic [7:0] asp_digit_char(input logic [3:0] d);
        return {4'h3, d};
    endfunction

    // evaluation of the received record
    always_comb begin
        ev_station = {cur_reg.rec[1][3:0], cur_reg.rec[2][3:0]};
        ev_cmd = {cur_reg.rec[8][3:0], cur_reg.rec[9][3:0]};
        ev_addr_ok = asp_is_digit(cur_reg.rec[1]) && asp_is_digit(cur_reg.rec[2])
            && (ev_station == asp_pkg::ASP_BCAST || ev_station == cur_reg.station);
        ev_cmd_ok = ev_cmd inside {asp_pkg::ASP_CMD_FSTOP, asp_pkg::ASP_CMD_RSTOP,
            asp_pkg::ASP_CMD_RUN, asp_pkg::ASP_CMD_MASTER, asp_pkg::ASP_CMD_FOLLOW,
            asp_pkg::ASP_CMD_SP13, asp_pkg::ASP_CMD_SP24};
        ev_err = asp_pkg::ASP_ERR_OK;
        for (int i = 4; i < 10; i++) begin
            if (!asp_is_digit(cur_reg.rec[i])) begin
                ev_err[asp_pkg::ASP_ERR_FMT_BIT] = 1'b1;
            end
        end
        if (cur_reg.short_rec || cur_reg.rec[11] != asp_pkg::ASP_ETX) begin
            ev_err[asp_pkg::ASP_ERR_FMT_BIT] = 1'b1;
        end
        if (cur_reg.rec[3] == asp_pkg::ASP_KIND_CTRL) begin
            for (int i = 4; i < 8; i++) begin
                if (cur_reg.rec[i] != asp_pkg::ASP_ZERO) begin
                    ev_err[asp_pkg::ASP_ERR_FMT_BIT] = 1'b1;
                end
            end
            if (cur_reg.rec[10] != asp_pkg::ASP_ZERO) begin
                ev_err[asp_pkg::ASP_ERR_FMT_BIT] = 1'b1;
            end
            if (!ev_cmd_ok) begin
                ev_err[asp_pkg::ASP_ERR_DATA_BIT] = 1'b1;
            end
        end else if (cur_reg.rec[3] == asp_pkg::ASP_KIND_INQ) begin
            for (int i = 6; i < 11; i++) begin
                if (cur_reg.rec[i] != asp_pkg::ASP_ZERO) begin
                    ev_err[asp_pkg::ASP_ERR_FMT_BIT] = 1'b1;
                end
            end
        end else if (cur_reg.rec[3] == asp_pkg::ASP_KIND_SEND) begin
            if (cur_reg.rec[10] < asp_pkg::ASP_ZERO
                || cur_reg.rec[10] > asp_pkg::ASP_SEND_FMT_MAX) begin
                ev_err[asp_pkg::ASP_ERR_CODE_BIT] = 1'b1;
            end
        end else begin
            ev_err[asp_pkg::ASP_ERR_FMT_BIT] = 1'b1;
        end
        // parity flag from the character layer
        ev_err[asp_pkg::ASP_ERR_PAR_BIT] = cur_reg.par_err;
    end

    // next state of the whole block
    always_comb begin
        cur_next = cur_reg;
        cur_next.fstop = 1'b0;
        cur_next.rstop = 1'b0;
        cur_next.par_wr = 1'b0;
        cur_next.rdata = '0;
        // register port: station setting and status readback
        if (reg_wr_i && reg_addr_i == asp_pkg::ASP_REG_STATION) begin
            cur_next.station = reg_wdata_i[7:0];
        end
        if (reg_rd_i) begin
            if (reg_addr_i == asp_pkg::ASP_REG_STATION) begin
                cur_next.rdata = {24'h000000, cur_reg.station};
            end else if (reg_addr_i == asp_pkg::ASP_REG_STATUS) begin
                cur_next.rdata = {16'h0000, cur_reg.err, 5'h00, cur_reg.spsel,
                    cur_reg.master, cur_reg.run};
            end
        end
        unique case (cur_reg.st)
            asp_pkg::ASP_IDLE: begin
                if (rx_valid_i && rx_char_i == asp_pkg::ASP_STX) begin
                    cur_next.rec = '0;
                    cur_next.rec[0] = asp_pkg::ASP_STX;
                    cur_next.cnt = 4'h1;
                    cur_next.par_err = rx_parity_err_i;
                    cur_next.short_rec = 1'b0;
                    cur_next.st = asp_pkg::ASP_RECV;
                end
            end
            asp_pkg::ASP_RECV: begin
                if (rx_valid_i) begin
                    cur_next.rec[cur_reg.cnt] = rx_char_i;
                    cur_next.par_err = cur_reg.par_err | rx_parity_err_i;
                    cur_next.cnt = cur_reg.cnt + 4'h1;
                    // twelfth char or early end closes the record
                    if (cur_reg.cnt == asp_pkg::ASP_LAST_IDX) begin
                        cur_next.st = asp_pkg::ASP_EVAL;
                    end else if (rx_char_i == asp_pkg::ASP_ETX) begin
                        cur_next.short_rec = 1'b1;
                        cur_next.st = asp_pkg::ASP_EVAL;
                    end
                end
            end
            asp_pkg::ASP_EVAL: begin
                if (!ev_addr_ok) begin
                    cur_next.st = asp_pkg::ASP_IDLE;
                end else begin
                    cur_next.err = ev_err;
                    cur_next.kind = cur_reg.rec[3];
                    cur_next.bcast = (ev_station == asp_pkg::ASP_BCAST);
                    cur_next.par_num = {cur_reg.rec[4][3:0], cur_reg.rec[5][3:0]};
                    if (cur_reg.rec[3] == asp_pkg::ASP_KIND_CTRL) begin
                        // act only on a clean record
                        if (ev_err == asp_pkg::ASP_ERR_OK) begin
                            unique case (ev_cmd)
                                asp_pkg::ASP_CMD_FSTOP: begin
                                    cur_next.fstop = 1'b1;
                                    cur_next.run = 1'b0;
                                end
                                asp_pkg::ASP_CMD_RSTOP: begin
                                    cur_next.rstop = 1'b1;
                                    cur_next.run = 1'b0;
                                end
                                asp_pkg::ASP_CMD_RUN: cur_next.run = 1'b1;
                                asp_pkg::ASP_CMD_MASTER: cur_next.master = 1'b1;
                                asp_pkg::ASP_CMD_FOLLOW: cur_next.master = 1'b0;
                                asp_pkg::ASP_CMD_SP13: cur_next.spsel = 1'b0;
                                asp_pkg::ASP_CMD_SP24: cur_next.spsel = 1'b1;
                                default: cur_next.run = cur_reg.run;
                            endcase
                        end
                        for (int i = 4; i < 11; i++) begin
                            cur_next.rec[i] = asp_pkg::ASP_ZERO;
                        end
                        cur_next.rec[1] = asp_digit_char(cur_reg.station[7:4]);
                        cur_next.rec[2] = asp_digit_char(cur_reg.station[3:0]);
                        cur_next.rec[3] = ev_err;
                        cur_next.rec[11] = asp_pkg::ASP_ETX;
                        if (ev_station == asp_pkg::ASP_BCAST) begin
                            cur_next.st = asp_pkg::ASP_IDLE;
                        end else begin
                            cur_next.tx_char = asp_pkg::ASP_STX;
                            cur_next.tx_valid = 1'b1;
                            cur_next.cnt = 4'h1;
                            cur_next.st = asp_pkg::ASP_SEND;
                        end
                    end else begin
                        cur_next.st = asp_pkg::ASP_FETCH;
                    end
                end
            end
            asp_pkg::ASP_FETCH: begin
                // parameter store answers in the same cycle the number is shown
                cur_next.err[asp_pkg::ASP_ERR_CODE_BIT] =
                    cur_reg.err[asp_pkg::ASP_ERR_CODE_BIT] | param_bad_i;
                if (cur_reg.kind == asp_pkg::ASP_KIND_SEND) begin
                    cur_next.err[asp_pkg::ASP_ERR_RANGE_BIT] = param_range_err_i;
                    cur_next.par_wr = (cur_reg.err == asp_pkg::ASP_ERR_OK)
                        && !param_bad_i && !param_range_err_i;
                    cur_next.par.num = cur_reg.par_num;
                    cur_next.par.data = {cur_reg.rec[6][3:0], cur_reg.rec[7][3:0],
                        cur_reg.rec[8][3:0], cur_reg.rec[9][3:0]};
                    cur_next.par.fmt = cur_reg.rec[10];
                    // host format kept in char eleven
                end else begin
                    // four value digits and store's format
                    for (int i = 0; i < 4; i++) begin
                        cur_next.rec[6+i] = asp_digit_char(param_value_i[15-4*i -: 4]);
                    end
                    // format code from the store, zero char when outside zero to ASP_FMT_MAX
                    cur_next.rec[10] = param_format_i;
                    if (param_format_i < asp_pkg::ASP_ZERO
                        || param_format_i > asp_pkg::ASP_FMT_MAX) begin
                        cur_next.rec[10] = asp_pkg::ASP_ZERO;
                    end
                end
                // own station digits in the reply
                cur_next.rec[1] = asp_digit_char(cur_reg.station[7:4]);
                cur_next.rec[2] = asp_digit_char(cur_reg.station[3:0]);
                cur_next.rec[3] = cur_next.err;
                cur_next.rec[11] = asp_pkg::ASP_ETX;
                if (cur_reg.bcast) begin
                    cur_next.st = asp_pkg::ASP_IDLE;
                end else begin
                    cur_next.tx_char = asp_pkg::ASP_STX;
                    cur_next.tx_valid = 1'b1;
                    cur_next.cnt = 4'h1;
                    cur_next.st = asp_pkg::ASP_SEND;
                end
            end
            asp_pkg::ASP_SEND: begin
                // reply walks all twelve chars ending in end-of-text
                if (tx_ready_i) begin
                    if (cur_reg.cnt == asp_pkg::ASP_REPLY_END) begin
                        cur_next.tx_valid = 1'b0;
                        cur_next.st = asp_pkg::ASP_IDLE;
                    end else begin
                        cur_next.tx_char = cur_reg.rec[cur_reg.cnt];
                        cur_next.cnt = cur_reg.cnt + 4'h1;
                    end
                end
            end
        endcase
    end

    // state register, frozen while the clock enable is low
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cur_reg <= '0;
            cur_reg.st <= asp_pkg::ASP_IDLE;
            cur_reg.err <= asp_pkg::ASP_ERR_OK;
            cur_reg.station <= STATION_RESET;
        end else if (clk_en_i) begin
            cur_reg <= cur_next;
        end
    end

    // outputs straight from state flops
    assign tx_char_o = cur_reg.tx_char;
    assign tx_valid_o = cur_reg.tx_valid;
    assign reg_rdata_o = cur_reg.rdata;
    assign param_num_o = cur_reg.par_num;
    assign param_wr_o = cur_reg.par_wr;
    assign param_wr_data_o = cur_reg.par;
    assign run_o = cur_reg.run;
    assign master_mode_o = cur_reg.master;
    assign setpoint_sel_o = cur_reg.spsel;
    assign fast_stop_o = cur_reg.fstop;
    assign ramp_stop_o = cur_reg.rstop;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_tx_last;
        tx_valid_o && tx_ready_i && clk_en_i && cur_reg.cnt == asp_pkg::ASP_REPLY_END;
    endsequence
    sequence s_eval_bcast;
        cur_reg.st == asp_pkg::ASP_EVAL && ev_addr_ok && ev_station == asp_pkg::ASP_BCAST;
    endsequence

    a_idle_ignore: assert property (cur_reg.st == asp_pkg::ASP_IDLE && clk_en_i
        && rx_valid_i && rx_char_i != asp_pkg::ASP_STX |=> cur_reg.st == asp_pkg::ASP_IDLE)
        else $error("stray char opened the buffer");
    a_foreign_drop: assert property (cur_reg.st == asp_pkg::ASP_EVAL && clk_en_i
        && !ev_addr_ok |=> cur_reg.st == asp_pkg::ASP_IDLE && !tx_valid_o)
        else $error("foreign record not dropped");
    a_bcast_silent: assert property (s_eval_bcast ##0 clk_en_i
        |=> !tx_valid_o [*3])
        else $error("reply sent to broadcast");
    a_cmd_run: assert property (cur_reg.st == asp_pkg::ASP_EVAL && clk_en_i && ev_addr_ok
        && cur_reg.rec[3] == asp_pkg::ASP_KIND_CTRL && ev_err == asp_pkg::ASP_ERR_OK
        && ev_cmd == asp_pkg::ASP_CMD_RUN |=> run_o)
        else $error("run command not applied");
    a_ctrl_zero: assert property (tx_valid_o && cur_reg.kind == asp_pkg::ASP_KIND_CTRL
        && cur_reg.cnt > 4'h4 && cur_reg.cnt < asp_pkg::ASP_REPLY_END
        |-> tx_char_o == asp_pkg::ASP_ZERO)
        else $error("control reply field not zero");
    a_err_frame: assert property ($rose(tx_valid_o) |-> cur_reg.rec[3][7:6] == 2'b01
        && !cur_reg.rec[3][0])
        else $error("error char framing wrong");
    // checks on acting only when clean and on the reply fields
    a_act_clean: assert property ($rose(run_o) |-> $past(ev_err) == asp_pkg::ASP_ERR_OK)
        else $error("acted on faulty record");
    a_wr_clean: assert property (param_wr_o |-> cur_reg.err == asp_pkg::ASP_ERR_OK)
        else $error("parameter written from faulty record");
    a_inq_format: assert property ($rose(tx_valid_o)
        && cur_reg.kind == asp_pkg::ASP_KIND_INQ |-> cur_reg.rec[10] >= asp_pkg::ASP_ZERO
        && cur_reg.rec[10] <= asp_pkg::ASP_FMT_MAX)
        else $error("inquiry format code out of range");
    a_send_fmt: assert property (param_wr_o
        |-> param_wr_data_o.fmt == cur_reg.rec[10])
        else $error("written format differs from host format");
    a_par_flag: assert property ($rose(tx_valid_o) && cur_reg.par_err
        |-> cur_reg.rec[3][asp_pkg::ASP_ERR_PAR_BIT])
        else $error("parity error not reported");
    a_rd_once: assert property ($past(clk_en_i) && reg_rdata_o != 32'h00000000
        |-> $past(reg_rd_i))
        else $error("read data outside its cycle");
    a_reply_start: assert property ($rose(tx_valid_o) |-> tx_char_o == asp_pkg::ASP_STX
        && cur_reg.rec[1] == asp_digit_char(cur_reg.station[7:4]))
        else $error("reply start wrong");
    a_reply_end: assert property (tx_valid_o && cur_reg.cnt == asp_pkg::ASP_REPLY_END
        |-> tx_char_o == asp_pkg::ASP_ETX)
        else $error("reply not ended by end-of-text");
    a_last_done: assert property (s_tx_last |=> !tx_valid_o)
        else $error("reply longer than twelve chars");
    a_digit_err: assert property (cur_reg.st == asp_pkg::ASP_EVAL && clk_en_i && ev_addr_ok
        && !asp_is_digit(cur_reg.rec[4]) |=> cur_reg.err[asp_pkg::ASP_ERR_FMT_BIT])
        else $error("non-digit not flagged");
endmodule // asp_parser

// File: sim/asp_host.sv
// Purpose: host computer model that polls the parser over the serial link
// Assumes: at most one character per cycle, same clock as the parser
// Notes: a released rx line shows the inverse of the last character, except after a stalling record, where it shows end-of-text
module asp_host (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic slow_i,
    input wire logic [7:0] tx_char_i,
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    output logic [7:0] rx_char_o,
    output logic rx_valid_o,
    output logic rx_parity_err_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] rep[$];
    logic ph_reg;
    // ready every other cycle while stalling
    assign tx_ready_o = !slow_i || ph_reg;
    // collect reply characters as they are taken
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ph_reg <= 1'b0;
        end else begin
            ph_reg <= !ph_reg;
            if (tx_valid_i && tx_ready_o) begin
                rep.push_back(tx_char_i);
            end
        end
    end
    initial begin
        rx_char_o = 8'h00;
        rx_valid_o = 1'b0;
        rx_parity_err_o = 1'b0;
    end
    // one character, with an idle gap when stalling
    task put(input logic [7:0] c, input logic pe);
        @(posedge clk_i);
        rx_char_o <= c;
        rx_valid_o <= 1'b1;
        rx_parity_err_o <= pe;
        if (slow_i) begin
            @(posedge clk_i);
            rx_valid_o <= 1'b0;
            rx_char_o <= ~c;
        end
    endtask
    // whole record: optional junk, start, ten body chars, end
    task send_rec(input string body, input logic pe, input logic [7:0] junk);
        if (junk != 8'h00) put(junk, 1'b0);
        put(asp_pkg::ASP_STX, 1'b0);
        for (int i = 0; i < 10; i++) put(body[i], pe && (i == 4));
        put(asp_pkg::ASP_ETX, 1'b0);
        @(posedge clk_i);
        rx_valid_o <= 1'b0;
        rx_parity_err_o <= 1'b0;
        rx_char_o <= ~rx_char_o;
    endtask
endmodule // asp_host

// File: sim/tb_asp_parser.sv
// Purpose: self-checking bench for the ascii serial command parser
// Assumes: host model drives the link, bench drives registers and store
// Notes: records are given as the ten chars between start and end
module tb_asp_parser;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic slow_i = 1'b0;
    logic clk_en_i = 1'b1;
    logic [7:0] rx_char, tx_char, reg_addr_i = 8'h00, param_num_o, param_format_i = 8'h30;
    logic rx_valid, rx_perr, tx_valid, tx_ready, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o;
    logic [15:0] param_value_i = 16'h0000;
    logic param_bad_i = 1'b0, param_range_err_i = 1'b0, param_wr_o;
    logic run_o, master_mode_o, setpoint_sel_o, fast_stop_o, ramp_stop_o;
    asp_pkg::asp_par_t param_wr_data_o;
    int miscompares = 0, num_checks = 0, n_fs = 0, n_rs = 0, n_wr = 0, cyc = 0;
    string cmds[7] = '{"04", "11", "05", "10", "02", "03", "01"};
    logic [2:0] exp_st[7] = '{3'b110, 3'b111, 3'b101, 3'b100, 3'b000, 3'b100, 3'b000};
    always #2 sys_clk_i = ~sys_clk_i;
    asp_host i_asp_host (.clk_i(sys_clk_i), .rst_n_i(rst_n_i), .slow_i(slow_i),
        .tx_char_i(tx_char), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready),
        .rx_char_o(rx_char), .rx_valid_o(rx_valid), .rx_parity_err_o(rx_perr));
    asp_parser i_asp_parser (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
        .rx_char_i(rx_char), .rx_valid_i(rx_valid), .rx_parity_err_i(rx_perr),
        .tx_char_o(tx_char), .tx_valid_o(tx_valid), .tx_ready_i(tx_ready),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .param_num_o(param_num_o),
        .param_value_i(param_value_i), .param_format_i(param_format_i),
        .param_bad_i(param_bad_i), .param_range_err_i(param_range_err_i),
        .param_wr_o(param_wr_o), .param_wr_data_o(param_wr_data_o), .run_o(run_o),
        .master_mode_o(master_mode_o), .setpoint_sel_o(setpoint_sel_o),
        .fast_stop_o(fast_stop_o), .ramp_stop_o(ramp_stop_o));
    // count pulses and cycles, cut a hang short
    always @(posedge sys_clk_i) begin
        n_fs += fast_stop_o;
        n_rs += ramp_stop_o;
        n_wr += param_wr_o;
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            print_verdict();
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            miscompares++;
        end
    endtask
    task reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task reg_read(input logic [7:0] a, input logic [31:0] exp);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b0;
        #1 chk(reg_rdata_o, exp);
    endtask
    // wait for the whole reply (or none), then compare it char by char
    task txn(input string body, input string exp, input logic pe = 1'b0,
        input logic [7:0] junk = 8'h00);
        int n;
        i_asp_host.send_rec(body, pe, junk);
        n = 0;
        while (i_asp_host.rep.size() < ((exp.len() > 0) ? 12 : 1) && n < 300) begin
            @(posedge sys_clk_i);
            n++;
        end
        #1 chk(i_asp_host.rep.size(), (exp.len() > 0) ? 12 : 0);
        if (exp.len() > 0 && i_asp_host.rep.size() == 12) begin
            chk(i_asp_host.rep[0], asp_pkg::ASP_STX);
            for (int i = 0; i < 10; i++) chk(i_asp_host.rep[i + 1], exp[i]);
            chk(i_asp_host.rep[11], asp_pkg::ASP_ETX);
        end
        i_asp_host.rep.delete();
    endtask
    task print_verdict();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        #1 chk({run_o, master_mode_o, setpoint_sel_o, tx_valid}, 4'h0);
        reg_read(8'h00, 32'h00000001);
        reg_read(8'h04, 32'h00004000);
        reg_read(8'h08, 32'h00000000);
        txn("0110000030", "01@0000000", 1'b0, 8'h58);
        chk(run_o, 1'b1);
        reg_read(8'h04, 32'h00004001);
        slow_i <= 1'b1;
        for (int k = 0; k < 7; k++) begin
            txn({"0110000", cmds[k], "0"}, "01@0000000");
            chk({run_o, master_mode_o, setpoint_sel_o}, exp_st[k]);
        end
        chk(n_fs, 1);
        chk(n_rs, 1);
        slow_i <= 1'b0;
        txn("0110000060", "01D0000000");
        txn("011A000030", "01H0000000");
        txn("0110000030", "01B0000000", 1'b1);
        chk(run_o, 1'b0);
        txn("0010000030", "");
        chk(run_o, 1'b1);
        txn("0210000010", "");
        chk({run_o, 8'(n_fs)}, 9'h101);
        param_value_i <= 16'h1234;
        param_format_i <= 8'h3B;
        txn("0121600000", "01@161234;");
        chk(param_num_o, 8'h16);
        param_bad_i <= 1'b1;
        txn("0121600000", "01P161234;");
        param_bad_i <= 1'b0;
        param_format_i <= 8'h3C;
        txn("0121600000", "01@1612340");
        txn("0131605230", "01@1605230");
        chk(param_wr_data_o, {8'h16, 16'h0523, 8'h30});
        chk(n_wr, 1);
        txn("0131605238", "01P1605238");
        param_range_err_i <= 1'b1;
        txn("0131699991", "01`1699991");
        chk(n_wr, 1);
        param_range_err_i <= 1'b0;
        reg_write(8'h00, 32'h00000007);
        reg_read(8'h00, 32'h00000007);
        txn("0710000020", "07@0000000");
        chk(n_rs, 2);
        // a write while the clock enable is low must not land
        clk_en_i <= 1'b0;
        reg_write(8'h00, 32'h00000009);
        clk_en_i <= 1'b1;
        reg_read(8'h00, 32'h00000007);
        print_verdict();
    end
endmodule // tb_asp_parser
